// ===== verilog/cbip_pkg.sv
package cbip_pkg;

    // clock and subcode clock generation timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SCLK_HALF_NS   = 400;
    localparam int SCLK_HALF_RAW  = SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_INT_STAT = 8'h08;
    localparam logic [7:0] OFF_INT_CLR  = 8'h0C;
    localparam logic [7:0] OFF_INT_EN   = 8'h10;
    localparam logic [7:0] OFF_DATA     = 8'h14;
    localparam logic [7:0] OFF_CD_AUDIO = 8'h18;
    localparam logic [7:0] OFF_SUBCODE  = 8'h1C;
    localparam logic [7:0] OFF_PICTURE  = 8'h20;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REQ_POL  = 2;
    localparam int CTRL_ACK_POL  = 3;
    localparam int CTRL_STB_SYNC = 4;
    localparam int CTRL_WS_POL   = 5;
    localparam int CTRL_SCLK_OUT = 6;
    localparam int CTRL_W        = 7;
    localparam logic [6:0] CTRL_RESET = 7'h2C;

    // status field positions
    localparam int ST_FILL_LSB = 0;
    localparam int ST_BYTE_LSB = 4;
    localparam int ST_HOLD     = 6;
    localparam int ST_SUB_LOCK = 7;
    localparam int ST_REQ      = 8;
    localparam int ST_CD_BAD   = 9;

    // interrupt event bit positions
    localparam int EV_WORD = 0;
    localparam int EV_OVF  = 1;
    localparam int EV_ERR  = 2;
    localparam int EV_CD   = 3;
    localparam int EV_SUB  = 4;
    localparam int EV_BLK  = 5;
    localparam int EV_W    = 6;

    // picture register: valid picture decoded
    localparam int PIC_DONE = 0;

    // buffer and word sizes
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW    = 3;
    localparam int CD_BITS    = 16;
    localparam int SUB_BITS   = 8;

    // shared pin bit positions
    localparam int PIN_DISC_SERIAL_AUDIO  = 0;
    localparam int PIN_CD_WS    = 1;
    localparam int PIN_DISC_BIT_CLOCK   = 2;
    localparam int PIN_CD_BAD   = 3;
    localparam int PIN_SUB_DATA = 4;
    localparam int PIN_SUB_FRM  = 5;
    localparam int PIN_SUB_BLK  = 6;
    localparam int PIN_SUB_CLK  = 7;

    typedef enum logic [1:0] {
        CBIP_MODE_PAR,
        CBIP_MODE_CD,
        CBIP_MODE_SUB,
        CBIP_MODE_OFF
    } cbip_mode_t;

    typedef enum logic {
        SUB_HUNT,
        SUB_RECV
    } cbip_sub_st_t;

    // pins as seen after synchronisation
    typedef struct packed {
        logic       err;
        logic       ack;
        logic       strobe;
        logic [7:0] data;
    } cbip_pins_t;

    // control register layout, lsb last
    typedef struct packed {
        logic       sclk_out;
        logic       ws_pol;
        logic       stb_sync;
        logic       ack_pol;
        logic       req_pol;
        cbip_mode_t mode;
    } cbip_ctrl_t;

endpackage

// ===== verilog/cbip_sync.sv
`timescale 1ns/1ps
module cbip_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // two stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ===== verilog/cbip_shift.sv
`timescale 1ns/1ps
module cbip_shift #(
    parameter int W = 8
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   clear,
    input  wire logic                   shift,
    input  wire logic                   bit_in,
    output logic      [W-1:0]           value,
    output logic      [$clog2(W+1)-1:0] count,
    output logic                        full
);

    localparam int CW = $clog2(W + 1);

    assign full = (count == CW'(W));

    // msb first shifter; clear with shift loads the first bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value <= '0;
            count <= '0;
        end
        else if (clear)
        begin
            value <= shift ? {{(W-1){1'b0}}, bit_in} : '0;
            count <= shift ? CW'(1) : '0;
        end
        else if (shift && !full)
        begin
            value <= {value[W-2:0], bit_in};
            count <= count + CW'(1);
        end
    end

endmodule

// ===== verilog/cbip_port.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Contract
// - request shows free buffer space, selectable polarity
// - sync mode: strobe is the data clock
// - sync mode: take data only with acknowledge
// - disc mode: serial audio on data bit zero
// - word sync frames 16-bit words, programmable polarity
// - any disc bit clock rate is accepted; here only rates slow enough for pclk to sample each level
// - corrupt flag high marks current byte bad
// - hold last picture until next valid one
// - subcode data with frame and block sync
// - subcode clock pin is input or output
module cbip_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  compressed_data,
    input  wire logic        input_transfer_strobe,
    input  wire logic        input_data_valid_ack,
    input  wire logic        input_error,
    output logic             input_space_request,
    output logic             subcode_clock_out,
    output logic             subcode_clock_oe,
    output logic             hold_last_picture,
    output logic             irq
);

    localparam int FW = cbip_pkg::FIFO_AW + 1;

    // level matches configured active polarity
    function automatic logic active(input logic lvl, input logic pol);
        active = (lvl == pol);
    endfunction

    // offsets that answer without error
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            cbip_pkg::OFF_CTRL, cbip_pkg::OFF_STATUS,
            cbip_pkg::OFF_INT_STAT, cbip_pkg::OFF_INT_CLR,
            cbip_pkg::OFF_INT_EN, cbip_pkg::OFF_DATA,
            cbip_pkg::OFF_CD_AUDIO, cbip_pkg::OFF_SUBCODE,
            cbip_pkg::OFF_PICTURE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    cbip_pkg::cbip_ctrl_t   ctrl;
    cbip_pkg::cbip_pins_t   pin_raw;
    cbip_pkg::cbip_pins_t   s;
    cbip_pkg::cbip_sub_st_t sub_st;
    logic [cbip_pkg::EV_W-1:0] ists;
    logic [cbip_pkg::EV_W-1:0] ien;
    logic [cbip_pkg::EV_W-1:0] ev;
    logic [31:0]            mem [cbip_pkg::FIFO_DEPTH];
    logic [cbip_pkg::FIFO_AW-1:0] wr_ptr;
    logic [cbip_pkg::FIFO_AW-1:0] rd_ptr;
    logic [FW-1:0]          fill;
    logic [1:0]             byte_cnt;
    logic [31:0]            word_acc;
    logic                   stb_q;
    logic                   bck_q;
    logic                   sclk_q;
    logic                   frm_q;
    logic                   blk_q;
    logic                   ws_last;
    logic                   cd_bad;
    logic                   cd_bad_word;
    logic [15:0]            cd_left;
    logic [15:0]            cd_right;
    logic [7:0]             sub_byte;
    logic [7:0]             div_cnt;
    logic                   acc;
    logic                   done;
    logic                   rd_ok;
    logic                   par_take;
    logic                   word_done;
    logic                   push;
    logic                   pop;
    logic                   bck_rise;
    logic                   ws_edge;
    logic                   sub_rise;
    logic                   frm_rise;
    logic                   blk_rise;
    logic                   div_tick;
    logic                   bad_now;
    logic [15:0]            cd_val;
    logic [$clog2(cbip_pkg::CD_BITS+1)-1:0]  cd_cnt;
    logic                   cd_full;
    logic [7:0]             sub_val;
    logic [$clog2(cbip_pkg::SUB_BITS+1)-1:0] sub_cnt;
    logic                   sub_full;
    logic                   space_ok;
    logic [31:0]            next_prdata;

    // all pins cross into pclk through two flops
    assign pin_raw = '{err: input_error, ack: input_data_valid_ack,
                       strobe: input_transfer_strobe,
                       data: compressed_data};

    cbip_sync #(.W($bits(cbip_pkg::cbip_pins_t))) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (pin_raw),
        .q     (s)
    );

    // previous synced levels for edge finding
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stb_q  <= 1'b0;
            bck_q  <= 1'b0;
            sclk_q <= 1'b0;
            frm_q  <= 1'b0;
            blk_q  <= 1'b0;
        end
        else
        begin
            stb_q  <= s.strobe;
            bck_q  <= s.data[cbip_pkg::PIN_DISC_BIT_CLOCK];
            sclk_q <= s.data[cbip_pkg::PIN_SUB_CLK];
            frm_q  <= s.data[cbip_pkg::PIN_SUB_FRM];
            blk_q  <= s.data[cbip_pkg::PIN_SUB_BLK];
        end
    end

    // async strobe edge takes a byte
    assign par_take = (ctrl.mode == cbip_pkg::CBIP_MODE_PAR) &&
                      s.strobe && !stb_q &&
                      (!ctrl.stb_sync || active(s.ack, ctrl.ack_pol));
    assign word_done = par_take && (byte_cnt == 2'd3);
    assign push      = word_done &&
                       (fill != FW'(cbip_pkg::FIFO_DEPTH));
    assign pop       = done && !pwrite &&
                       (paddr == cbip_pkg::OFF_DATA) && rd_ok;

    // first byte lands in the msb
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_cnt <= 2'd0;
            word_acc <= 32'h0000_0000;
        end
        else if (ctrl.mode != cbip_pkg::CBIP_MODE_PAR)
        begin
            byte_cnt <= 2'd0;
        end
        else if (par_take)
        begin
            byte_cnt <= byte_cnt + 2'd1;
            word_acc <= {word_acc[23:0], s.data};
        end
    end

    // compressed input buffer
    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wr_ptr] <= {word_acc[23:0], s.data};
    end

    // buffer pointers and fill level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            fill <= fill + FW'(push) - FW'(pop);
        end
    end

    // partial word counts as taken space
    assign space_ok = (fill + FW'(byte_cnt != 2'd0)) <
                      FW'(cbip_pkg::FIFO_DEPTH);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            input_space_request <= 1'b0;
        else if (ctrl.mode == cbip_pkg::CBIP_MODE_PAR && space_ok)
            input_space_request <= ctrl.req_pol;
        else
            input_space_request <= !ctrl.req_pol;
    end

    // edges found by sampling, any slower rate
    assign bck_rise = (ctrl.mode == cbip_pkg::CBIP_MODE_CD) &&
                      s.data[cbip_pkg::PIN_DISC_BIT_CLOCK] && !bck_q;
    assign ws_edge  = bck_rise &&
                      (s.data[cbip_pkg::PIN_CD_WS] != ws_last);

    cbip_shift #(.W(cbip_pkg::CD_BITS)) u_cd (
        .clk    (pclk),
        .rst_n  (presetn),
        .clear  (ws_edge),
        .shift  (bck_rise),
        .bit_in (s.data[cbip_pkg::PIN_DISC_SERIAL_AUDIO]),
        .value  (cd_val),
        .count  (cd_cnt),
        .full   (cd_full)
    );

    // sync change closes a 16-bit word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ws_last     <= 1'b0;
            cd_left     <= 16'h0000;
            cd_right    <= 16'h0000;
            cd_bad      <= 1'b0;
            cd_bad_word <= 1'b0;
        end
        else if (bck_rise)
        begin
            ws_last <= s.data[cbip_pkg::PIN_CD_WS];
            if (ws_edge && cd_full)
            begin
                if (active(ws_last, ctrl.ws_pol))
                    cd_right <= cd_val;
                else
                    cd_left <= cd_val;
                cd_bad_word <= cd_bad;
            end
            if (ws_edge)
                cd_bad <= s.data[cbip_pkg::PIN_CD_BAD];
            else
                cd_bad <= cd_bad | s.data[cbip_pkg::PIN_CD_BAD];
        end
    end

    // subcode clock from pin or divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt           <= 8'h00;
            subcode_clock_out <= 1'b0;
            subcode_clock_oe  <= 1'b0;
        end
        else
        begin
            subcode_clock_oe <= (ctrl.mode == cbip_pkg::CBIP_MODE_SUB) &&
                                ctrl.sclk_out;
            if (div_cnt == 8'(cbip_pkg::SCLK_HALF_CYC - 1))
            begin
                div_cnt           <= 8'h00;
                subcode_clock_out <= !subcode_clock_out;
            end
            else
                div_cnt <= div_cnt + 8'h01;
        end
    end

    assign div_tick = (div_cnt == 8'(cbip_pkg::SCLK_HALF_CYC - 1)) &&
                      !subcode_clock_out;
    assign sub_rise = (ctrl.mode == cbip_pkg::CBIP_MODE_SUB) &&
                      (sub_st == cbip_pkg::SUB_RECV) &&
                      (ctrl.sclk_out ? div_tick :
                       (s.data[cbip_pkg::PIN_SUB_CLK] && !sclk_q));
    assign frm_rise = (ctrl.mode == cbip_pkg::CBIP_MODE_SUB) &&
                      s.data[cbip_pkg::PIN_SUB_FRM] && !frm_q;
    assign blk_rise = (ctrl.mode == cbip_pkg::CBIP_MODE_SUB) &&
                      s.data[cbip_pkg::PIN_SUB_BLK] && !blk_q;

    cbip_shift #(.W(cbip_pkg::SUB_BITS)) u_sub (
        .clk    (pclk),
        .rst_n  (presetn),
        .clear  (frm_rise || blk_rise || sub_full),
        .shift  (sub_rise),
        .bit_in (s.data[cbip_pkg::PIN_SUB_DATA]),
        .value  (sub_val),
        .count  (sub_cnt),
        .full   (sub_full)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_st   <= cbip_pkg::SUB_HUNT;
            sub_byte <= 8'h00;
        end
        else
        begin
            case (sub_st)
                cbip_pkg::SUB_HUNT:
                    if (frm_rise)
                        sub_st <= cbip_pkg::SUB_RECV;
                cbip_pkg::SUB_RECV:
                    if (ctrl.mode != cbip_pkg::CBIP_MODE_SUB)
                        sub_st <= cbip_pkg::SUB_HUNT;
                default:
                    sub_st <= cbip_pkg::SUB_HUNT;
            endcase
            if (sub_full)
                sub_byte <= sub_val;
        end
    end

    // error pin sampled with each byte, corrupt pin with each bit clock rise
    assign bad_now = (par_take && s.err) ||
                     (bck_rise && s.data[cbip_pkg::PIN_CD_BAD]);

    // event pulses into the sticky status
    always_comb
    begin
        ev = '0;
        ev[cbip_pkg::EV_WORD] = push;
        ev[cbip_pkg::EV_OVF]  = word_done && !push;
        ev[cbip_pkg::EV_ERR]  = bad_now;
        ev[cbip_pkg::EV_CD]   = ws_edge && cd_full;
        ev[cbip_pkg::EV_SUB]  = sub_full;
        ev[cbip_pkg::EV_BLK]  = blk_rise;
    end

    assign acc  = psel && penable;
    assign done = acc && pready;

    // hold set by bad data, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_last_picture <= 1'b0;
        else if (bad_now)
            hold_last_picture <= 1'b1;
        else if (done && pwrite && paddr == cbip_pkg::OFF_PICTURE &&
                 pwdata[cbip_pkg::PIC_DONE])
            hold_last_picture <= 1'b0;
    end

    // sticky status, enable and interrupt line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ists <= '0;
            ien  <= '0;
            irq  <= 1'b0;
        end
        else
        begin
            if (done && pwrite && paddr == cbip_pkg::OFF_INT_CLR)
                ists <= (ists & ~pwdata[cbip_pkg::EV_W-1:0]) | ev;
            else
                ists <= ists | ev;
            if (done && pwrite && paddr == cbip_pkg::OFF_INT_EN)
                ien <= pwdata[cbip_pkg::EV_W-1:0];
            irq <= |(ists & ien);
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= cbip_pkg::CTRL_RESET;
        else if (done && pwrite && paddr == cbip_pkg::OFF_CTRL)
            ctrl <= pwdata[cbip_pkg::CTRL_W-1:0];
    end

    // read data mux
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            cbip_pkg::OFF_CTRL:
                next_prdata[cbip_pkg::CTRL_W-1:0] = ctrl;
            cbip_pkg::OFF_STATUS:
            begin
                next_prdata[cbip_pkg::ST_FILL_LSB +: FW] = fill;
                next_prdata[cbip_pkg::ST_BYTE_LSB +: 2]  = byte_cnt;
                next_prdata[cbip_pkg::ST_HOLD]     = hold_last_picture;
                next_prdata[cbip_pkg::ST_SUB_LOCK] =
                    (sub_st == cbip_pkg::SUB_RECV);
                next_prdata[cbip_pkg::ST_REQ]      = input_space_request;
                next_prdata[cbip_pkg::ST_CD_BAD]   = cd_bad_word;
            end
            cbip_pkg::OFF_INT_STAT:
                next_prdata[cbip_pkg::EV_W-1:0] = ists;
            cbip_pkg::OFF_INT_EN:
                next_prdata[cbip_pkg::EV_W-1:0] = ien;
            cbip_pkg::OFF_DATA:
                next_prdata = (fill != '0) ? mem[rd_ptr] : 32'h0000_0000;
            cbip_pkg::OFF_CD_AUDIO:
                next_prdata = {cd_right, cd_left};
            cbip_pkg::OFF_SUBCODE:
                next_prdata[7:0] = sub_byte;
            default:
                next_prdata = 32'h0000_0000;
        endcase
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            rd_ok   <= 1'b0;
        end
        else if (acc && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            rd_ok   <= (fill != '0);
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            rd_ok   <= 1'b0;
        end
    end

endmodule

// ===== bench/cbip_properties.sv
`timescale 1ns/1ps
module cbip_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        subcode_clock_out,
    input wire logic        hold_last_picture,
    input wire logic        irq
);
    // all checks on the bus clock
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // write landing at this edge
    wire logic wr_done = psel && penable && pready && pwrite;

    property p_wait;
        psel && $rose(penable) |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("ready late");

    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");

    property p_in_access;
        pready |-> psel && penable;
    endproperty
    a_in_access: assert property (p_in_access) else $error("ready idle");

    property p_refuse;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad refusal");

    property p_sclk_high;
        $rose(subcode_clock_out) |-> subcode_clock_out [*4];
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("clock high time");

    property p_sclk_low;
        $fell(subcode_clock_out) |-> !subcode_clock_out [*4];
    endproperty
    a_sclk_low: assert property (p_sclk_low)
        else $error("clock low time");

    property p_hold;
        hold_last_picture && !(wr_done && pwdata[0]
            && paddr == cbip_pkg::OFF_PICTURE) |=> hold_last_picture;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold lost");

    property p_irq_off;
        wr_done && paddr == cbip_pkg::OFF_INT_EN && pwdata[5:0] == 6'h00
            |-> ##2 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not masked");
endmodule

bind cbip_port cbip_chk u_cbip_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .subcode_clock_out,
    .hold_last_picture, .irq
);

// ===== bench/cbip_source.sv
`timescale 1ns/1ps
module cbip_source (
    input  wire logic       pclk,
    input  wire logic       request,
    output logic      [7:0] data,
    output logic            strobe,
    output logic            ack,
    output logic            err
);
    // idle pins, error line grounded
    // no error source
    initial
    begin
        data = 8'h00;
        strobe = 1'b0;
        ack = 1'b0;
        err = 1'b0;
    end

    int late = 0;

    // one byte framed round the strobe rise
    task automatic send_byte(input logic [7:0] b, input logic a);
        for (int i = 0; i < 300 && request !== 1'b1; i++)
            @(posedge pclk);
        if (request !== 1'b1)
            late++;
        data <= b;
        ack <= a;
        @(posedge pclk);
        strobe <= 1'b1;
        repeat (4) @(posedge pclk);
        strobe <= 1'b0;
        data <= ~b;
        ack <= ~a;
        repeat (4) @(posedge pclk);
    endtask

    // one audio word, closed by a sync change
    task automatic send_cd(input logic [15:0] w, input logic bad,
                           input int h);
        for (int i = 0; i < 17; i++)
        begin
            data[0] <= w[4'(15 - i)];
            data[1] <= (i < 16);
            data[3] <= bad;
            data[2] <= 1'b0;
            repeat (h) @(posedge pclk);
            data[2] <= 1'b1;
            repeat (h) @(posedge pclk);
        end
        data[2] <= 1'b0;
        data[3] <= 1'b0;
        data[0] <= ~data[0];
        repeat (4) @(posedge pclk);
    endtask
endmodule

// ===== bench/test_compressed_bitstream_input_port.sv
`timescale 1ns/1ps
module test_compressed_bitstream_input_port;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, cdata;
    logic [31:0] pwdata, prdata, rd;
    logic        stb, ack, ierr, req, sclk, sclk_oe, hold, irq, er;
    int          err_count = 0;
    int          checks = 0;

    cbip_port u_cbip_port (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq,
        .compressed_data(cdata),
        .input_transfer_strobe(stb),
        .input_data_valid_ack(ack),
        .input_error(ierr),
        .input_space_request(req),
        .subcode_clock_out(sclk),
        .subcode_clock_oe(sclk_oe),
        .hold_last_picture(hold)
    );
    cbip_source u_cbip_source (
        .pclk, .request(req), .data(cdata), .strobe(stb), .ack, .err(ierr)
    );

    // bus clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask

    // one bus transfer, waits for ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n == 50)
        begin
            chk("pready", 1'b1, 1'b0);
            print_verdict;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_regs;
        apb(0, cbip_pkg::OFF_CTRL, 0);
        chk("ctrl", cbip_pkg::CTRL_RESET, rd);
        chk("request", 1'b1, req);
        apb(0, 8'h24, 0);
        chk("slverr", 1'b1, er);
        chk("unmapped", 0, rd);
        $display("t_regs done");
    endtask

    task automatic t_par;
        apb(1, cbip_pkg::OFF_INT_EN, 32'h0000_0001);
        for (int i = 1; i < 5; i++)
            u_cbip_source.send_byte(8'(i * 17), 1'b1);
        repeat (4) @(posedge pclk);
        chk("irq", 1'b1, irq);
        apb(1, cbip_pkg::OFF_INT_EN, 0);
        repeat (2) @(posedge pclk);
        chk("masked", 1'b0, irq);
        apb(0, cbip_pkg::OFF_DATA, 0);
        chk("word", 32'h1122_3344, rd);
        apb(1, cbip_pkg::OFF_INT_CLR, 32'h0000_003F);
        apb(0, cbip_pkg::OFF_INT_STAT, 0);
        chk("cleared", 0, rd);
        $display("t_par done");
    endtask

    task automatic t_full;
        for (int i = 0; i < 28; i++)
            u_cbip_source.send_byte(8'(i), 1'b1);
        chk("room", 1'b1, req);
        u_cbip_source.send_byte(8'hA0, 1'b1);
        repeat (3) @(posedge pclk);
        chk("full", 1'b0, req);
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_0028);
        repeat (3) @(posedge pclk);
        chk("low active", 1'b1, req);
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_002C);
        for (int k = 0; k < 8; k++)
        begin
            apb(0, cbip_pkg::OFF_DATA, 0);
            chk("drain", (k < 7) ? {8'(4 * k), 8'(4 * k + 1),
                8'(4 * k + 2), 8'(4 * k + 3)} : 0, rd);
        end
        chk("space", 1'b1, req);
        $display("t_full done");
    endtask

    task automatic t_cd;
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_002D);
        u_cbip_source.send_cd(16'hA5A5, 1'b0, 4);
        chk("cd req", 1'b0, req);
        apb(0, cbip_pkg::OFF_CD_AUDIO, 0);
        chk("right", 16'hA5A5, rd[31:16]);
        chk("no hold", 1'b0, hold);
        u_cbip_source.send_cd(16'h8001, 1'b1, 2);
        apb(0, cbip_pkg::OFF_CD_AUDIO, 0);
        chk("fast", 16'h8001, rd[31:16]);
        apb(0, cbip_pkg::OFF_STATUS, 0);
        chk("corrupt", 1'b1, rd[9]);
        chk("hold", 1'b1, hold);
        apb(1, cbip_pkg::OFF_PICTURE, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("release", 1'b0, hold);
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_006E);
        u_cbip_source.data[5] <= 1'b1;
        @(posedge pclk);
        chk("drive", 1'b1, sclk_oe);
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_002E);
        @(posedge pclk);
        chk("listen", 1'b0, sclk_oe);
        apb(0, cbip_pkg::OFF_STATUS, 0);
        chk("lock", 1'b1, rd[7]);
        $display("t_cd done");
    endtask

    // byte four has ack inactive and is ignored
    task automatic t_sync;
        apb(1, cbip_pkg::OFF_CTRL, 32'h0000_003C);
        for (int i = 1; i < 6; i++)
            u_cbip_source.send_byte((i == 4) ? 8'hFF : 8'(i - i / 5),
                                    i != 4);
        repeat (4) @(posedge pclk);
        apb(0, cbip_pkg::OFF_DATA, 0);
        chk("sync word", 32'h0102_0304, rd);
        $display("t_sync done");
    endtask

    // reset, then scenarios
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_par;
        t_full;
        t_cd;
        t_sync;
        chk("late", 0, u_cbip_source.late);
        print_verdict;
    end
endmodule
